// ---- core/adc_fmt_pkg.sv ----
// Constants, register map and type definitions for the converter output block.
// Assumes a single 20 MHz APB clock domain; shared by the top and the bench.
package adc_fmt_pkg;

   // ---------------------------------------------------------------
   // Widths and clock
   // ---------------------------------------------------------------
   localparam int DATA_W = 16;            // Converter word width
   localparam int ADDR_W = 8;             // APB address bits decoded
   localparam int CLK_PERIOD_NS = 50;     // pclk period at 20 MHz

   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_OFF = 8'h00;      // Mode override control
   localparam logic [7:0] STATUS_OFF = 8'h04;    // Live state, read only
   localparam logic [7:0] IRQ_STAT_OFF = 8'h08;  // Sticky events, read only
   localparam logic [7:0] IRQ_EN_OFF = 8'h0c;    // Interrupt enables
   localparam logic [7:0] IRQ_CLR_OFF = 8'h10;   // Write one to clear
   localparam logic [7:0] DATA_OFF = 8'h14;      // Last output word

   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int CTRL_OVR_BIT = 0;       // Software mode replaces the pin
   localparam int CTRL_MODE_LSB = 1;      // Two-bit software mode level
   localparam logic [2:0] CTRL_RESET = 3'h0;
   localparam int ST_TWOS_BIT = 0;        // Two's complement in use
   localparam int ST_STAB_BIT = 1;        // Stabilizer in use
   localparam int ST_LOCK_BIT = 2;        // Output data valid
   localparam int ST_GAIN_BIT = 3;        // Narrow range selected
   localparam int ST_OF_BIT = 4;          // Current overflow flag
   localparam int IRQ_W = 3;              // Number of event bits
   localparam int IRQ_OF_BIT = 0;         // Overflow word emitted
   localparam int IRQ_LOCK_BIT = 1;       // Stabilizer locked
   localparam int IRQ_LOST_BIT = 2;       // Input clock stopped while the stabilizer is in use
   localparam logic [2:0] IRQ_EN_RESET = 3'h0;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int LATENCY = 7;            // Samples from capture to output
   localparam int LOCK_EDGES_I = 100;     // Input clock edges to lock
   localparam logic [6:0] LOCK_EDGES = 7'(LOCK_EDGES_I);
   localparam int STOP_TIME_NS = 10000;   // Gap that counts as stopped clock
   localparam logic [7:0] STOP_CYCLES =
      8'((STOP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   // Four-level configuration pin, quantised by the analog front end
   typedef enum logic [1:0] {
      MODE_GND = 2'b00,
      MODE_THIRD = 2'b01,
      MODE_TWO_THIRD = 2'b10,
      MODE_FULL = 2'b11
   } mode_level_t;

   // Stabilizer lock progress, Gray coded along idle, acquire, locked
   typedef enum logic [1:0] {
      LK_IDLE = 2'b00,
      LK_ACQ = 2'b01,
      LK_DONE = 2'b11
   } lock_state_t;

endpackage

// ---- core/sample_delay_line.sv ----
// Fixed-depth shift line that delays converter words by whole samples.
// Assumes the caller supplies a one-cycle advance pulse per sample.
`timescale 1ns/1ps
`default_nettype none
module sample_delay_line #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 7
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Stream
   input wire logic advance,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);

   // ---------------------------------------------------------------
   // Stages
   // ---------------------------------------------------------------
   logic [WIDTH-1:0] stage_q [DEPTH];  // Held words
   logic [WIDTH-1:0] stage_d [DEPTH];  // Next words

   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_stage
         // Each stage moves one step only on a sample
         always_comb begin
            if (advance) begin
               stage_d[g] = (g == 0) ? din : stage_q[(g == 0) ? 0 : g - 1];
            end else begin
               stage_d[g] = stage_q[g];
            end
         end
         // Register the stage
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               stage_q[g] <= '0;
            end else begin
               stage_q[g] <= stage_d[g];
            end
         end
      end
   endgenerate

   // Oldest word leaves at the end
   assign dout = stage_q[DEPTH-1];

endmodule
`default_nettype wire

// ---- core/adc_output_format_and_clock_mode.sv ----
// Output formatting, clock stabilizer model and APB control for the converter.
// Assumes core codes arrive offset binary and the sample clock level is synchronous to pclk.
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module adc_output_format_and_clock_mode (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Interrupt
   output logic irq,
   // Converter core and configuration pins
   input wire logic sample_clock,
   input wire logic [1:0] mode_level,
   input wire logic gain_range_select,
   input wire logic output_scramble_enable,
   input wire logic [15:0] core_code,
   input wire logic core_over_range,
   input wire logic core_under_range,
   // Front end control
   output logic front_end_narrow,
   // Output bus to the receiver
   output logic [15:0] data_out,
   output logic range_overflow_flag,
   output logic output_clock_true,
   output logic output_clock_inverted,
   output logic data_valid
);

   // ---------------------------------------------------------------
   // Decode helpers
   // ---------------------------------------------------------------
   // Two's complement for the two upper pin levels
   function automatic logic level_is_twos(input logic [1:0] lvl);
      level_is_twos = (lvl == adc_fmt_pkg::MODE_TWO_THIRD) ||
                      (lvl == adc_fmt_pkg::MODE_FULL);
   endfunction

   // Stabilizer only on the two middle levels
   function automatic logic level_has_stab(input logic [1:0] lvl);
      level_has_stab = (lvl == adc_fmt_pkg::MODE_THIRD) ||
                       (lvl == adc_fmt_pkg::MODE_TWO_THIRD);
   endfunction

   // Mapped register offsets
   function automatic logic addr_mapped(input logic [7:0] a);
      addr_mapped = (a == adc_fmt_pkg::CTRL_OFF) || (a == adc_fmt_pkg::STATUS_OFF) ||
                    (a == adc_fmt_pkg::IRQ_STAT_OFF) || (a == adc_fmt_pkg::IRQ_EN_OFF) ||
                    (a == adc_fmt_pkg::IRQ_CLR_OFF) || (a == adc_fmt_pkg::DATA_OFF);
   endfunction

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic [2:0] ctrl_q, ctrl_d;                 // Override bit and software level
   logic [2:0] irq_en_q, irq_en_d;             // Interrupt enables
   logic [2:0] irq_stat_q, irq_stat_d;         // Sticky event bits
   logic [31:0] prdata_q, prdata_d;            // Read data, loaded at setup
   logic clk_prev_q;                           // Sample clock one pclk ago
   logic stab_prev_q;                          // Stabilizer mode one pclk ago
   logic [7:0] period_q, period_d;             // Last measured sample period
   logic [7:0] since_fall_q, since_fall_d;     // pclk since last falling edge
   logic phase_q, phase_d;                     // Internal clock phase
   adc_fmt_pkg::lock_state_t lock_q, lock_d;   // Stabilizer lock state
   logic [6:0] edges_q, edges_d;               // Edges seen while acquiring
   logic [15:0] data_q, data_d;                // Output word
   logic of_q, of_d;                           // Output overflow flag
   logic gain_q, gain_d;                       // Front end range
   logic [1:0] level;                          // Effective mode level
   logic twos;                                 // Two's complement chosen
   logic stab;                                 // Stabilizer chosen
   logic sample_evt;                           // Falling edge of sample clock
   logic stopped;                              // No edge for the stop time
   logic [16:0] tap;                           // Delayed {flag, code}
   logic [15:0] coded;                         // Word after format
   logic acc;                                  // APB access phase
   logic wr;                                   // Accepted write
   logic [2:0] ev;                             // Events this cycle

   // ---------------------------------------------------------------
   // Mode selection
   // ---------------------------------------------------------------
   // Software may replace the pin level for bring-up
   always_comb begin
      if (ctrl_q[adc_fmt_pkg::CTRL_OVR_BIT]) begin
         level = ctrl_q[adc_fmt_pkg::CTRL_MODE_LSB +: 2];
      end else begin
         level = mode_level;
      end
      twos = level_is_twos(level);
      stab = level_has_stab(level);
   end

   // Sampling happens on the falling edge in both modes
   assign sample_evt = clk_prev_q & ~sample_clock;
   // Gap measured in pclk; assumes the source stays above its floor rate
   assign stopped = (since_fall_q >= adc_fmt_pkg::STOP_CYCLES);

   // ---------------------------------------------------------------
   // Pipeline latency
   // ---------------------------------------------------------------
   // Flag travels with its own word so both leave together
   sample_delay_line #(
      .WIDTH(adc_fmt_pkg::DATA_W + 1),
      .DEPTH(adc_fmt_pkg::LATENCY)
   ) u_delay (
      .clk(pclk),
      .rst_n(presetn),
      .advance(sample_evt),
      .din({core_over_range | core_under_range, core_code}),
      .dout(tap)
   );

   // ---------------------------------------------------------------
   // Output word formatting
   // ---------------------------------------------------------------
   // Format first, scramble second, so the receiver undoes in reverse
   always_comb begin
      coded = tap[15:0];
      if (twos) begin
         coded[15] = ~tap[15];
      end
      if (output_scramble_enable) begin
         coded[15:1] = coded[15:1] ^ {15{coded[0]}};
      end
      data_d = data_q;
      of_d = of_q;
      if (sample_evt) begin
         data_d = coded;
         of_d = tap[16];
      end
      gain_d = gain_range_select;
   end

   // Output registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_q <= '0;
         of_q <= 1'b0;
         gain_q <= 1'b0;
      end else begin
         data_q <= data_d;
         of_q <= of_d;
         gain_q <= gain_d;
      end
   end

   // ---------------------------------------------------------------
   // Clock stabilizer and output clock
   // ---------------------------------------------------------------
   // Period is measured between falls; the rising edge is placed at half of it
   always_comb begin
      period_d = period_q;
      since_fall_d = since_fall_q;
      if (sample_evt) begin
         period_d = since_fall_q + 8'h01;
         since_fall_d = 8'h00;
      end else if (since_fall_q != 8'hff) begin
         since_fall_d = since_fall_q + 8'h01;
      end
      if (sample_evt) begin
         phase_d = 1'b0;
      end else if (stab) begin
         // Input rising edge ignored; duty follows only the period
         phase_d = phase_q | (since_fall_q + 8'h01 >= {1'b0, period_q[7:1]});
      end else begin
         // Without stabilizer the source must give a clean duty
         phase_d = sample_clock;
      end
   end

   // Stabilizer registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_prev_q <= 1'b0;
         stab_prev_q <= 1'b0;
         period_q <= 8'h02;
         since_fall_q <= 8'h00;
         phase_q <= 1'b0;
      end else begin
         clk_prev_q <= sample_clock;
         stab_prev_q <= stab;
         period_q <= period_d;
         since_fall_q <= since_fall_d;
         phase_q <= phase_d;
      end
   end

   // ---------------------------------------------------------------
   // Lock tracking
   // ---------------------------------------------------------------
   // Data are flagged invalid until the loop has seen enough edges
   always_comb begin
      lock_d = lock_q;
      edges_d = edges_q;
      case (lock_q)
         adc_fmt_pkg::LK_IDLE: begin
            if (!stab) begin
               lock_d = adc_fmt_pkg::LK_DONE;
            end else if (sample_evt) begin
               lock_d = adc_fmt_pkg::LK_ACQ;
               edges_d = 7'h01;
            end
         end
         adc_fmt_pkg::LK_ACQ: begin
            if (!stab) begin
               lock_d = adc_fmt_pkg::LK_DONE;
            end else if (stopped) begin
               lock_d = adc_fmt_pkg::LK_IDLE;
            end else if (sample_evt) begin
               edges_d = edges_q + 7'h01;
               if (edges_q + 7'h01 >= adc_fmt_pkg::LOCK_EDGES) begin
                  lock_d = adc_fmt_pkg::LK_DONE;
               end
            end
         end
         adc_fmt_pkg::LK_DONE: begin
            if (stab && !stab_prev_q) begin
               // Stabilizer just switched on: acquire from scratch
               lock_d = adc_fmt_pkg::LK_ACQ;
               edges_d = 7'h00;
            end else if (stab && stopped) begin
               lock_d = adc_fmt_pkg::LK_IDLE;
            end
         end
         default: begin
            lock_d = adc_fmt_pkg::LK_IDLE;
         end
      endcase
   end

   // Lock registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_q <= adc_fmt_pkg::LK_IDLE;
         edges_q <= 7'h00;
      end else begin
         lock_q <= lock_d;
         edges_q <= edges_d;
      end
   end

   // ---------------------------------------------------------------
   // APB registers and interrupts
   // ---------------------------------------------------------------
   assign acc = psel & penable;
   assign wr = acc & pwrite;

   // Events from the block's own logic
   always_comb begin
      ev = '0;
      ev[adc_fmt_pkg::IRQ_OF_BIT] = sample_evt & tap[16];
      ev[adc_fmt_pkg::IRQ_LOCK_BIT] = (lock_q == adc_fmt_pkg::LK_ACQ) &&
                                      (lock_d == adc_fmt_pkg::LK_DONE);
      ev[adc_fmt_pkg::IRQ_LOST_BIT] = (lock_q != adc_fmt_pkg::LK_IDLE) &&
                                      (lock_d == adc_fmt_pkg::LK_IDLE);
   end

   // Next register values; a set in the clear cycle survives
   always_comb begin
      ctrl_d = ctrl_q;
      irq_en_d = irq_en_q;
      irq_stat_d = irq_stat_q;
      if (wr && paddr == adc_fmt_pkg::CTRL_OFF) begin
         ctrl_d = pwdata[2:0];
      end
      if (wr && paddr == adc_fmt_pkg::IRQ_EN_OFF) begin
         irq_en_d = pwdata[2:0];
      end
      if (wr && paddr == adc_fmt_pkg::IRQ_CLR_OFF) begin
         irq_stat_d = irq_stat_q & ~pwdata[2:0];
      end
      irq_stat_d = irq_stat_d | ev;
      // Read data captured in setup so it is a flop at access
      prdata_d = prdata_q;
      if (psel && !penable) begin
         prdata_d = '0;
         case (paddr)
            adc_fmt_pkg::CTRL_OFF: prdata_d[2:0] = ctrl_q;
            adc_fmt_pkg::STATUS_OFF: begin
               prdata_d[adc_fmt_pkg::ST_TWOS_BIT] = twos;
               prdata_d[adc_fmt_pkg::ST_STAB_BIT] = stab;
               prdata_d[adc_fmt_pkg::ST_LOCK_BIT] = (lock_q == adc_fmt_pkg::LK_DONE);
               prdata_d[adc_fmt_pkg::ST_GAIN_BIT] = gain_q;
               prdata_d[adc_fmt_pkg::ST_OF_BIT] = of_q;
            end
            adc_fmt_pkg::IRQ_STAT_OFF: prdata_d[2:0] = irq_stat_q;
            adc_fmt_pkg::IRQ_EN_OFF: prdata_d[2:0] = irq_en_q;
            adc_fmt_pkg::DATA_OFF: prdata_d[15:0] = data_q;
            default: prdata_d = '0;
         endcase
      end
   end

   // Register bank
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= adc_fmt_pkg::CTRL_RESET;
         irq_en_q <= adc_fmt_pkg::IRQ_EN_RESET;
         irq_stat_q <= '0;
         prdata_q <= '0;
      end else begin
         ctrl_q <= ctrl_d;
         irq_en_q <= irq_en_d;
         irq_stat_q <= irq_stat_d;
         prdata_q <= prdata_d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign pready = 1'b1;
   assign pslverr = acc & ~addr_mapped(paddr);
   assign prdata = prdata_q;
   assign irq = |(irq_stat_q & irq_en_q);
   assign front_end_narrow = gain_q;
   assign data_out = data_q;
   assign range_overflow_flag = of_q;
   assign output_clock_true = phase_q;
   assign output_clock_inverted = ~phase_q;
   assign data_valid = (lock_q == adc_fmt_pkg::LK_DONE);

endmodule
`default_nettype wire

// ---- sim/adc_fmt_props.sv ----
// Checker for the converter output block: clock pair, update timing, lock, APB errors.
// Assumes it is bound to the top module and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module adc_fmt_props (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB and interrupt
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pslverr,
   input wire logic irq,
   // Converter side
   input wire logic sample_clock,
   input wire logic [1:0] mode_level,
   input wire logic gain_range_select,
   input wire logic front_end_narrow,
   input wire logic [15:0] data_out,
   input wire logic range_overflow_flag,
   input wire logic output_clock_true,
   input wire logic output_clock_inverted,
   input wire logic data_valid
);
   // ----------------------------------------
   // Helper counters
   // ----------------------------------------
   logic sc_q; // Last sample clock level
   logic dv_q; // Last valid level
   logic [1:0] mode_q; // Last mode level
   logic [7:0] idle_q, idle_d; // Cycles since last fall, saturating
   logic [6:0] falls_q, falls_d; // Falls since mode change or lock loss
   logic fall; // Sample edge seen this cycle
   logic stab; // Stabilizer selected
   assign fall = sc_q & ~sample_clock;
   assign stab = mode_level == 2'h1 || mode_level == 2'h2;
   // Next counts; saturation keeps old stops from wrapping into false hits
   always_comb begin
      idle_d = fall ? 8'h00 : (idle_q == 8'hff ? idle_q : idle_q + 8'h01);
      falls_d = falls_q;
      if (mode_q != mode_level || (dv_q && !data_valid)) begin
         falls_d = 7'h00;
      end else if (fall && falls_q != 7'h7f) begin
         falls_d = falls_q + 7'h01;
      end
   end
   // Registers of the helper state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sc_q <= 1'b0;
         dv_q <= 1'b0;
         mode_q <= 2'h0;
         idle_q <= 8'hff;
         falls_q <= 7'h00;
      end else begin
         sc_q <= sample_clock;
         dv_q <= data_valid;
         mode_q <= mode_level;
         idle_q <= idle_d;
         falls_q <= falls_d;
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_clk_pair_inverse: assert property (output_clock_inverted == !output_clock_true)
      else $error("output clock pair not complementary");
   a_update_clock_low: assert property ($changed(data_out) |-> !output_clock_true)
      else $error("data changed while output clock high");
   a_update_after_fall: assert property ($changed(data_out) |-> idle_q <= 8'h03)
      else $error("data changed away from a sample edge");
   a_flag_with_word: assert property ($changed(range_overflow_flag) |-> !output_clock_true)
      else $error("flag changed outside a word update");
   a_gain_follows: assert property ($past(presetn) |-> front_end_narrow == $past(gain_range_select))
      else $error("range select not passed to front end");
   a_unmapped_err: assert property (psel && penable |-> pslverr == (paddr > 8'h14 || paddr[1:0] != 2'h0))
      else $error("slave error wrong for address");
   a_lock_count: assert property ($rose(data_valid) && stab |-> falls_q >= 7'h63)
      else $error("lock declared before enough clock falls");
   a_stab_off_valid: assert property ((mode_level == 2'h0 || mode_level == 2'h3) [*4] |-> data_valid)
      else $error("valid low with stabilizer off");
   a_stop_drops_lock: assert property (idle_q == 8'hd2 && stab |-> !data_valid)
      else $error("lock kept after clock stopped");
   c_locked: cover property ($rose(data_valid) && stab);
   c_slverr: cover property (pslverr);
   c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

// ---- sim/output_receiver_model.sv ----
// Downstream receiver: latches the output bus on the true output clock, undoes scrambling.
// Assumes the scramble level it sees matches the one the words were formed with.
`timescale 1ns/1ps
`default_nettype none
module output_receiver_model (
   // Bus from the converter
   input wire logic output_clock_true,
   input wire logic output_scramble_enable,
   input wire logic [15:0] data_out,
   input wire logic range_overflow_flag,
   // Recovered sample
   output logic [15:0] rx_word,
   output logic rx_flag
);
   // Latch on the rising true clock, data settled since its fall
   always @(posedge output_clock_true) begin
      if (output_scramble_enable) begin
         rx_word <= {data_out[15:1] ^ {15{data_out[0]}}, data_out[0]};
      end else begin
         rx_word <= data_out;
      end
      rx_flag <= range_overflow_flag;
   end
endmodule
`default_nettype wire

// ---- sim/adc_output_format_and_clock_mode_tb_top.sv ----
// Self-checking bench for the converter output block, receiver model and checker.
// Assumes one 20 MHz clock; the sample clock is made from it by the bench.
`timescale 1ns/1ps
`default_nettype none
module adc_output_format_and_clock_mode_tb_top;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic sample_clock, gain_range_select, output_scramble_enable, core_over_range;
   logic core_under_range, front_end_narrow, range_overflow_flag, output_clock_true;
   logic output_clock_inverted, data_valid, rx_flag, er;
   logic [1:0] mode_level;
   logic [15:0] core_code, data_out, rx_word;
   logic [36:0] rows [8]; // Mode, scramble, code, over, under, word
   int errors, n_tests, cyc;
   adc_output_format_and_clock_mode dut (.*);
   output_receiver_model rx (.*);
   // ----------------------------------------
   // Clock, timeout and helpers
   // ----------------------------------------
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // Ceiling well above the roughly 1400 cycles the run needs
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         tally_and_finish();
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // One APB transfer; waits for pready, the bench timeout bounds it
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk("register", rd & m, e);
   endtask
   // One sample period, half high and half low; code held across the falling edge
   task automatic sample(input logic [15:0] c, input logic o, input logic u);
      @(posedge pclk);
      sample_clock <= 1'b1;
      core_code <= c;
      core_over_range <= o;
      core_under_range <= u;
      repeat (3) @(posedge pclk);
      sample_clock <= 1'b0;
      repeat (2) @(posedge pclk);
      @(negedge pclk);
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      rows = '{{2'h0, 1'b0, 16'h8000, 2'b00, 16'h8000}, {2'h1, 1'b1, 16'h0001, 2'b00, 16'hffff},
               {2'h2, 1'b0, 16'h0000, 2'b01, 16'h8000}, {2'h3, 1'b1, 16'hffff, 2'b10, 16'h8001},
               {2'h0, 1'b1, 16'h7fff, 2'b00, 16'h8001}, {2'h3, 1'b0, 16'h1234, 2'b00, 16'h9234},
               {2'h2, 1'b1, 16'h8001, 2'b00, 16'hffff}, {2'h1, 1'b0, 16'habcd, 2'b00, 16'habcd}};
      {presetn, psel, penable, pwrite, paddr, pwdata, sample_clock, mode_level} = '0;
      {gain_range_select, output_scramble_enable, core_code} = '0;
      {core_over_range, core_under_range} = '0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk("clk_inv", output_clock_inverted, 1);
      rdchk(adc_fmt_pkg::CTRL_OFF, 32'hffffffff, 0);
      rdchk(adc_fmt_pkg::IRQ_EN_OFF, 32'hffffffff, 0);
      rdchk(8'h18, 32'hffffffff, 0);
      chk("pslverr", er, 1);
      apb(1'b1, adc_fmt_pkg::STATUS_OFF, 32'h1f);
      rdchk(adc_fmt_pkg::STATUS_OFF, 32'hffffffff, 32'h4);
      @(posedge pclk) gain_range_select <= 1'b1;
      rdchk(adc_fmt_pkg::STATUS_OFF, 32'h8, 32'h8);
      chk("narrow", front_end_narrow, 1);
      @(posedge pclk) gain_range_select <= 1'b0;
      $display("test registers done");
      // Distinct words expose the exact depth; zeros fill the line first
      for (int i = 0; i < 10; i++) begin
         sample(16'(i * 4369), i == 2, 1'b0);
         chk("data", data_out, i < 7 ? 0 : 16'((i - 7) * 4369));
         chk("flag", range_overflow_flag, i == 9);
      end
      $display("test latency done");
      foreach (rows[r]) begin
         @(posedge pclk) mode_level <= rows[r][36:35];
         output_scramble_enable <= rows[r][34];
         repeat (9) sample(rows[r][33:18], rows[r][17], rows[r][16]);
         chk("data", data_out, rows[r][15:0]);
         chk("flag", range_overflow_flag, |rows[r][17:16]);
         chk("rx", rx_word, rows[r][33:18] ^ {rows[r][36], 15'h0});
      end
      $display("test formats done");
      rdchk(adc_fmt_pkg::IRQ_STAT_OFF, 32'h1, 32'h1);
      chk("irq", irq, 0);
      apb(1'b1, adc_fmt_pkg::IRQ_EN_OFF, 32'h1);
      chk("irq", irq, 1);
      apb(1'b1, adc_fmt_pkg::IRQ_CLR_OFF, 32'h1);
      chk("irq", irq, 0);
      rdchk(adc_fmt_pkg::IRQ_STAT_OFF, 32'h1, 32'h0);
      $display("test interrupt done");
      @(posedge pclk) mode_level <= 2'h0;
      repeat (3) @(posedge pclk);
      mode_level <= 2'h1;
      output_scramble_enable <= 1'b0;
      repeat (99) sample(16'h5a5a, 1'b0, 1'b0);
      chk("valid", data_valid, 0);
      sample(16'h5a5a, 1'b0, 1'b0);
      chk("valid", data_valid, 1);
      rdchk(adc_fmt_pkg::STATUS_OFF, 32'h1f, 32'h6);
      apb(1'b1, adc_fmt_pkg::IRQ_EN_OFF, 32'h4);
      repeat (220) @(posedge pclk);
      @(negedge pclk);
      chk("valid", data_valid, 0);
      chk("irq", irq, 1);
      apb(1'b1, adc_fmt_pkg::IRQ_CLR_OFF, 32'h4);
      chk("irq", irq, 0);
      $display("test lock done");
      @(posedge pclk) mode_level <= 2'h0;
      apb(1'b1, adc_fmt_pkg::CTRL_OFF, 32'h7);
      rdchk(adc_fmt_pkg::STATUS_OFF, 32'h3, 32'h1);
      @(posedge pclk) presetn <= 1'b0;
      @(negedge pclk);
      chk("data", data_out, 0);
      chk("clk_inv", output_clock_inverted, 1);
      @(posedge pclk) presetn <= 1'b1;
      rdchk(adc_fmt_pkg::IRQ_EN_OFF, 32'hffffffff, 0);
      $display("test reset done");
      tally_and_finish();
   end
endmodule
bind adc_output_format_and_clock_mode adc_fmt_props chk_i (.*);
`default_nettype wire
